//--- bench/core_cpu_model.sv
`timescale 1ns/10ps
module core_cpu_model (
   input  wire logic                           clk_sys,
   output core_status_option_pkg::alu_req_type alu_req
);
   // ------------------------------------------------------------
   // alu instruction issue
   // ------------------------------------------------------------
   initial alu_req = '0;

   // rotate fill bit is a constant: only the carry out is judged
   task automatic issue(input core_status_option_pkg::alu_op_type op,
                        input logic [7:0] w,
                        input logic [7:0] f);
      logic [7:0] r;
      case (op)
         core_status_option_pkg::OP_ADD:  r = f + w;
         core_status_option_pkg::OP_SUB:  r = f - w;
         core_status_option_pkg::OP_ROTR: r = {1'b0, f[7:1]};
         core_status_option_pkg::OP_ROTL: r = {f[6:0], 1'b0};
         default:                         r = f & w;
      endcase
      @(posedge clk_sys);
      alu_req <= '{1'b1, op, w, f, r};
      @(posedge clk_sys);
      alu_req.valid <= 1'b0;
   endtask : issue
endmodule : core_cpu_model

//--- bench/core_status_option_regs_tb_top.sv
`timescale 1ns/10ps
module core_status_option_regs_tb_top;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   // ev: core reset, file write, watchdog clear, sleep, timeout, load
   logic                                clk_sys = 1'b0;
   logic                                rst_n = 1'b0;
   logic [5:0]                          ev = 6'h00;
   logic [4:0]                          addr = 5'h00;
   logic [7:0]                          data = 8'h00;
   core_status_option_pkg::alu_req_type alu_req;
   logic [7:0]                          status_q;
   logic [10:0]                         page_base;
   core_status_option_pkg::option_type  option_q;
   logic [3:0]                          tdiv;
   logic [3:0]                          wdiv;
   int                                  mismatches = 0;
   int                                  cmp_count = 0;

   always #2 clk_sys = ~clk_sys;

   core_cpu_model i_core_cpu_model (.clk_sys(clk_sys), .alu_req(alu_req));

   core_status_option_regs i_core_status_option_regs (
      .CLK_SYS(clk_sys), .RST_N(rst_n), .CORE_RESET(ev[5]),
      .FILE_WE(ev[4]), .FILE_ADDR(addr), .FILE_WDATA(data),
      .ALU_REQ(alu_req), .WATCHDOG_CLEAR(ev[3]), .SLEEP_EXEC(ev[2]),
      .WATCHDOG_TIMEOUT(ev[1]), .OPTION_LOAD(ev[0]), .W_REG(data),
      .STATUS_Q(status_q), .PAGE_BASE(page_base), .OPTION_Q(option_q),
      .TIMER_DIV_LOG2(tdiv), .WATCHDOG_DIV_LOG2(wdiv));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [10:0] a, input logic [10:0] e,
                      input string m);
      cmp_count++;
      if (a !== e) begin
         mismatches++;
         $display("Error at %0t: %s got %h want %h", $time, m, a, e);
      end
   endtask : chk

   // one-cycle strobes; returns once the result is visible
   task automatic drv(input logic [5:0] v, input logic [7:0] d,
                      input logic [4:0] a);
      @(posedge clk_sys);
      ev   <= v;
      data <= d;
      addr <= a;
      @(posedge clk_sys);
      ev <= 6'h00;
      #1;
   endtask : drv

   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : test_done

   initial begin
      repeat (5000) @(posedge clk_sys);
      mismatches++;
      test_done();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      logic [23:0] at [11];
      logic [3:0]  evs [5];
      logic [1:0]  tp [5];
      logic [7:0]  d;
      // {op, w, f, expected zero/nibble/carry}
      at = '{{5'h01, 8'h01, 8'h0f, 3'h2}, {5'h01, 8'h01, 8'hff, 3'h7},
             {5'h01, 8'h80, 8'h80, 3'h5}, {5'h01, 8'h07, 8'h08, 3'h0},
             {5'h02, 8'h05, 8'h05, 3'h7}, {5'h02, 8'h01, 8'h10, 3'h1},
             {5'h02, 8'h02, 8'h01, 3'h0}, {5'h04, 8'h00, 8'h01, 3'h1},
             {5'h08, 8'h00, 8'h7f, 3'h0}, {5'h08, 8'h00, 8'h80, 3'h1},
             {5'h10, 8'h0f, 8'hf0, 3'h5}};
      evs = '{4'h2, 4'h8, 4'h4, 4'ha, 4'h4};
      tp  = '{2'h1, 2'h3, 2'h2, 2'h1, 2'h2};
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1;
      chk(status_q, 8'h18, "status reset");
      chk(option_q, 6'h3f, "option reset");
      chk({tdiv, wdiv}, 8'h87, "ratio reset");
      chk(page_base, 11'h000, "page base reset");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         d = {2'b11, ~i[2:0], i[2:0]};
         drv(6'h01, d, 5'h03);
         chk(option_q, d[5:0], "option load");
         chk({tdiv, wdiv}, {i[3:0] + 4'h1, i[3:0]}, "ratio");
         chk(status_q, 8'h18, "status after load");
      end
      $display("test option done");
      for (int p = 0; p < 4; p++) begin
         drv(6'h10, {1'b0, p[1:0], 5'h00}, 5'h03);
         chk(status_q, {1'b0, p[1:0], 5'h18}, "page write");
         @(posedge clk_sys);
         #1;
         chk(page_base, {p[1:0], 9'h000}, "page base");
      end
      drv(6'h10, 8'h07, 5'h04);
      chk(status_q, 8'h78, "other address");
      drv(6'h10, 8'h02, 5'h03);
      chk(status_q, 8'h1a, "flag write");
      $display("test page done");
      for (int k = 0; k < 11; k++) begin
         i_core_cpu_model.issue(
            core_status_option_pkg::alu_op_type'(at[k][23:19]),
            at[k][18:11], at[k][10:3]);
         #1;
         chk(status_q[2:0], at[k][2:0], "alu flags");
      end
      fork
         i_core_cpu_model.issue(core_status_option_pkg::OP_ROTR,
                                8'h00, 8'h00);
         drv(6'h10, 8'h07, 5'h03);
      join
      chk(status_q, 8'h1c, "write under alu");
      $display("test alu done");
      for (int j = 0; j < 5; j++) begin
         drv({2'b00, evs[j]}, 8'h00, 5'h00);
         chk(status_q[4:3], tp[j], "timeout powerdown");
      end
      $display("test events done");
      drv(6'h11, 8'h60, 5'h03);
      chk(status_q, 8'h70, "write and load");
      chk(option_q, 6'h20, "load with write");
      drv(6'h20, 8'h00, 5'h00);
      chk(status_q, 8'h10, "core reset");
      chk(option_q, 6'h3f, "core reset option");
      @(posedge clk_sys);
      rst_n <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(status_q, 8'h18, "second reset");
      $display("test resets done");
      test_done();
   end
endmodule : core_status_option_regs_tb_top

//--- design/core_status_option_pkg.sv
package core_status_option_pkg;

   // ----------------------------------------------------------------
   // register map and field positions
   // ----------------------------------------------------------------
   localparam logic [4:0] STATUS_ADDR      = 5'h03;
   localparam int         RESERVED_PAGE_BIT = 7;
   localparam int         PAGE_HI          = 6;
   localparam int         PAGE_LO          = 5;
   localparam int         TIMEOUT_BIT      = 4;
   localparam int         POWERDOWN_BIT    = 3;
   localparam int         ZERO_BIT         = 2;
   localparam int         NIBBLE_BIT       = 1;
   localparam int         CARRY_BIT        = 0;

   localparam int         SOURCE_BIT       = 5;
   localparam int         EDGE_BIT         = 4;
   localparam int         ASSIGN_BIT       = 3;
   localparam int         RATIO_HI         = 2;

   // ----------------------------------------------------------------
   // reset values and sizes
   // ----------------------------------------------------------------
   localparam logic [5:0] OPTION_RESET     = 6'h3f;
   localparam logic [2:0] ALU_FLAGS_RESET  = 3'h0;
   localparam int         PAGE_WORDS_LOG2  = 9;
   localparam logic [3:0] TIMER_LOG2_BASE  = 4'h1;

   // ----------------------------------------------------------------
   // alu flag update request
   // ----------------------------------------------------------------
   typedef enum logic [4:0] {
      OP_ADD   = 5'b00001,
      OP_SUB   = 5'b00010,
      OP_ROTR  = 5'b00100,
      OP_ROTL  = 5'b01000,
      OP_LOGIC = 5'b10000
   } alu_op_type;

   typedef struct packed {
      logic       valid;
      alu_op_type op;
      logic [7:0] w;
      logic [7:0] f;
      logic [7:0] result;
   } alu_req_type;

   typedef struct packed {
      logic       source_sel;
      logic       edge_sel;
      logic       assign_watchdog;
      logic [2:0] ratio;
   } option_type;

endpackage : core_status_option_pkg

//--- design/core_status_option_regs.sv
// Contract
// - page select value 0..3 picks one of four 512-word code pages
// - timeout flag is 1 after power-up, watchdog clear or sleep; 0 on timeout
// - powerdown flag is 1 after power-up or watchdog clear; 0 on sleep
// - zero flag follows whether an alu result equals zero
// - on add, nibble carry flag is the carry out of bit 3
// - on add, carry flag is the carry out of bit 7
// - rotate right or left loads carry with operand bit 0 or bit 7
// - alu flag updates block direct writes; timeout, powerdown never written
// - option register is six bits and cannot be read back
// - the option-load instruction copies the working register into option
// - any reset sets all six option bits to one
// - source select 1 counts the external pin, 0 the instruction clock
// - edge select 1 counts falling pin edges, 0 rising edges
// - prescaler goes to the watchdog when 1, to the timer when 0; TIMER_DIV_LOG2 loads the ratio plus 1 and WATCHDOG_DIV_LOG2 the ratio regardless
`timescale 1ns/10ps
module core_status_option_regs (
   input  wire logic                               CLK_SYS,
   input  wire logic                               RST_N,
   input  wire logic                               CORE_RESET,
   input  wire logic                               FILE_WE,
   input  wire logic [4:0]                         FILE_ADDR,
   input  wire logic [7:0]                         FILE_WDATA,
   input  wire core_status_option_pkg::alu_req_type ALU_REQ,
   input  wire logic                               WATCHDOG_CLEAR,
   input  wire logic                               SLEEP_EXEC,
   input  wire logic                               WATCHDOG_TIMEOUT,
   input  wire logic                               OPTION_LOAD,
   input  wire logic [7:0]                         W_REG,
   output logic      [7:0]                         STATUS_Q,
   output logic      [10:0]                        PAGE_BASE,
   output core_status_option_pkg::option_type      OPTION_Q,
   output logic      [3:0]                         TIMER_DIV_LOG2,
   output logic      [3:0]                         WATCHDOG_DIV_LOG2
);

   // ----------------------------------------------------------------
   // alu flag evaluation
   // ----------------------------------------------------------------
   localparam logic [2:0] ALU_FLAGS_RESET_C =
      core_status_option_pkg::ALU_FLAGS_RESET;

   logic       status_wr;
   logic [2:0] next_alu_flags;
   logic [2:0] alu_flag_en;
   logic [8:0] sum;
   logic [4:0] nib_sum;
   logic [7:0] diff;

   assign status_wr = FILE_WE &&
                      FILE_ADDR == core_status_option_pkg::STATUS_ADDR;

   always_comb begin
      sum            = {1'b0, ALU_REQ.f} + {1'b0, ALU_REQ.w};
      nib_sum        = {1'b0, ALU_REQ.f[3:0]} + {1'b0, ALU_REQ.w[3:0]};
      diff           = ALU_REQ.f - ALU_REQ.w;
      next_alu_flags = ALU_FLAGS_RESET_C;
      alu_flag_en    = 3'h0;
      case (ALU_REQ.op)
         core_status_option_pkg::OP_ADD: begin
            next_alu_flags = {sum[7:0] == 8'h00, nib_sum[4],
                              sum[8]};
            alu_flag_en    = 3'h7;
         end
         core_status_option_pkg::OP_SUB: begin
            next_alu_flags = {diff == 8'h00,
                              ALU_REQ.f[3:0] >= ALU_REQ.w[3:0],
                              ALU_REQ.f >= ALU_REQ.w};
            alu_flag_en    = 3'h7;
         end
         core_status_option_pkg::OP_ROTR: begin
            next_alu_flags = {2'h0, ALU_REQ.f[0]};
            alu_flag_en    = 3'h1;
         end
         core_status_option_pkg::OP_ROTL: begin
            next_alu_flags = {2'h0, ALU_REQ.f[7]};
            alu_flag_en    = 3'h1;
         end
         core_status_option_pkg::OP_LOGIC: begin
            next_alu_flags = {ALU_REQ.result == 8'h00, 2'h0};
            alu_flag_en    = 3'h4;
         end
         default: begin
            next_alu_flags = ALU_FLAGS_RESET_C;
            alu_flag_en    = 3'h0;
         end
      endcase
      if (!ALU_REQ.valid) begin
         alu_flag_en = 3'h0;
      end
   end

   // ----------------------------------------------------------------
   // status register
   // ----------------------------------------------------------------
   // the reserved page bit is stored like any other writable bit; giving
   // it meaning is left to software
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         STATUS_Q[7:5] <= 3'h0;
      end else if (CORE_RESET) begin
         STATUS_Q[7:5] <= 3'h0;
      end else if (status_wr) begin
         STATUS_Q[7:5] <= FILE_WDATA[7:5];
      end
   end

   // timeout wins over a clear in the same cycle so no time-out is lost
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         STATUS_Q[core_status_option_pkg::TIMEOUT_BIT] <= 1'b1;
      end else if (WATCHDOG_TIMEOUT) begin
         STATUS_Q[core_status_option_pkg::TIMEOUT_BIT] <= 1'b0;
      end else if (WATCHDOG_CLEAR || SLEEP_EXEC) begin
         STATUS_Q[core_status_option_pkg::TIMEOUT_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         STATUS_Q[core_status_option_pkg::POWERDOWN_BIT] <= 1'b1;
      end else if (SLEEP_EXEC) begin
         STATUS_Q[core_status_option_pkg::POWERDOWN_BIT] <= 1'b0;
      end else if (WATCHDOG_CLEAR) begin
         STATUS_Q[core_status_option_pkg::POWERDOWN_BIT] <= 1'b1;
      end
   end

   // per flag: alu result first, then a direct write
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_alu_flag
         always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
               STATUS_Q[g] <= ALU_FLAGS_RESET_C[g];
            end else if (alu_flag_en[g]) begin
               STATUS_Q[g] <= next_alu_flags[g];
            end else if (status_wr && !ALU_REQ.valid) begin
               STATUS_Q[g] <= FILE_WDATA[g];
            end
         end
      end
   endgenerate

   // page base follows the stored page field one cycle later
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PAGE_BASE <= 11'h000;
      end else begin
         PAGE_BASE <= {STATUS_Q[core_status_option_pkg::PAGE_HI:
                                core_status_option_pkg::PAGE_LO],
                       9'h000};
      end
   end

   // ----------------------------------------------------------------
   // option register
   // ----------------------------------------------------------------
   // there is no read path: the contents only steer the timer outputs
   localparam logic [3:0] WATCHDOG_LOG2_RESET =
      {1'b0, core_status_option_pkg::OPTION_RESET[2:0]};
   localparam logic [3:0] TIMER_LOG2_RESET =
      WATCHDOG_LOG2_RESET + core_status_option_pkg::TIMER_LOG2_BASE;

   logic [3:0] next_timer_log2;
   assign next_timer_log2 = {1'b0, W_REG[2:0]} +
                            core_status_option_pkg::TIMER_LOG2_BASE;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         OPTION_Q <= core_status_option_pkg::OPTION_RESET;
      end else if (CORE_RESET) begin
         OPTION_Q <= core_status_option_pkg::OPTION_RESET;
      end else if (OPTION_LOAD) begin
         OPTION_Q <= W_REG[5:0];
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         TIMER_DIV_LOG2    <= TIMER_LOG2_RESET;
         WATCHDOG_DIV_LOG2 <= WATCHDOG_LOG2_RESET;
      end else if (CORE_RESET) begin
         TIMER_DIV_LOG2    <= TIMER_LOG2_RESET;
         WATCHDOG_DIV_LOG2 <= WATCHDOG_LOG2_RESET;
      end else if (OPTION_LOAD) begin
         TIMER_DIV_LOG2    <= next_timer_log2;
         WATCHDOG_DIV_LOG2 <= {1'b0, W_REG[2:0]};
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_timeout_clear;
      @(posedge CLK_SYS) disable iff (!RST_N)
      WATCHDOG_TIMEOUT |=> !STATUS_Q[4];
   endproperty
   a_timeout_clear: assert property (p_timeout_clear)
      else $error("timeout flag not cleared");

   property p_sleep_flags;
      @(posedge CLK_SYS) disable iff (!RST_N)
      SLEEP_EXEC && !WATCHDOG_TIMEOUT |=> STATUS_Q[4:3] == 2'b10;
   endproperty
   a_sleep_flags: assert property (p_sleep_flags)
      else $error("sleep flags wrong");

   property p_clear_flags;
      @(posedge CLK_SYS) disable iff (!RST_N)
      WATCHDOG_CLEAR && !SLEEP_EXEC && !WATCHDOG_TIMEOUT
         |=> STATUS_Q[4:3] == 2'b11;
   endproperty
   a_clear_flags: assert property (p_clear_flags)
      else $error("watchdog clear flags wrong");

   property p_add_flags;
      @(posedge CLK_SYS) disable iff (!RST_N)
      ALU_REQ.valid && ALU_REQ.op == core_status_option_pkg::OP_ADD
         |=> STATUS_Q[2] ==
                (8'($past(ALU_REQ.f)) + 8'($past(ALU_REQ.w)) == 8'h00) &&
             STATUS_Q[1] == (5'($past(ALU_REQ.f[3:0])) +
                             5'($past(ALU_REQ.w[3:0])) > 5'h0f) &&
             STATUS_Q[0] == (9'($past(ALU_REQ.f)) +
                             9'($past(ALU_REQ.w)) > 9'h0ff);
   endproperty
   a_add_flags: assert property (p_add_flags)
      else $error("add flags wrong");

   property p_sub_carry;
      @(posedge CLK_SYS) disable iff (!RST_N)
      ALU_REQ.valid && ALU_REQ.op == core_status_option_pkg::OP_SUB
         |=> STATUS_Q[1] == ($past(ALU_REQ.f[3:0]) >= $past(ALU_REQ.w[3:0]));
   endproperty
   a_sub_carry: assert property (p_sub_carry)
      else $error("subtract nibble flag wrong");

   property p_rotate;
      @(posedge CLK_SYS) disable iff (!RST_N)
      ALU_REQ.valid && (ALU_REQ.op == core_status_option_pkg::OP_ROTL ||
                        ALU_REQ.op == core_status_option_pkg::OP_ROTR)
         |=> STATUS_Q[0] ==
             ($past(ALU_REQ.op) == core_status_option_pkg::OP_ROTL ?
              $past(ALU_REQ.f[7]) : $past(ALU_REQ.f[0]));
   endproperty
   a_rotate: assert property (p_rotate)
      else $error("rotate carry wrong");

   property p_tdpd_unwritable;
      @(posedge CLK_SYS) disable iff (!RST_N)
      status_wr && !WATCHDOG_TIMEOUT && !WATCHDOG_CLEAR && !SLEEP_EXEC
         |=> $stable(STATUS_Q[4:3]);
   endproperty
   a_tdpd_unwritable: assert property (p_tdpd_unwritable)
      else $error("timeout or powerdown written");

   property p_option_load;
      @(posedge CLK_SYS) disable iff (!RST_N)
      OPTION_LOAD && !CORE_RESET
         |=> OPTION_Q == $past(W_REG[5:0]) &&
             WATCHDOG_DIV_LOG2 == {1'b0, $past(W_REG[2:0])} &&
             TIMER_DIV_LOG2 == WATCHDOG_DIV_LOG2 + 4'h1;
   endproperty
   a_option_load: assert property (p_option_load)
      else $error("option load wrong");

   property p_option_reset;
      @(posedge CLK_SYS) disable iff (!RST_N)
      CORE_RESET |=> OPTION_Q == 6'h3f && STATUS_Q[7:5] == 3'h0;
   endproperty
   a_option_reset: assert property (p_option_reset)
      else $error("reset values wrong");

   property p_page_base;
      @(posedge CLK_SYS) disable iff (!RST_N)
      1'b1 |=> PAGE_BASE == {$past(STATUS_Q[6:5]), 9'h000};
   endproperty
   a_page_base: assert property (p_page_base)
      else $error("page base wrong");

endmodule : core_status_option_regs
